// File: src/ipp_pkg.sv
// Package for the instruction phase pipeline: constants and carrier types
package ipp_pkg;
   localparam int IPP_NUM_PHASES = 4;
   localparam int IPP_PC_WIDTH = 14;
   localparam int IPP_DATA_WIDTH = 8;
   localparam int IPP_PAGE_BITS = 8;
   localparam logic [13:0] IPP_PC_RESET = 14'h0000;
   localparam logic [7:0] IPP_ACC_RESET = 8'h00;
   localparam logic [3:0] IPP_PHASE_RESET = 4'h1;
   // Instruction class codes presented with each fetched word
   typedef enum logic [2:0] {
      IPP_OP_NOP, IPP_OP_ALU, IPP_OP_BRANCH, IPP_OP_SKIP, IPP_OP_PCL_WRITE
   } ipp_op_t;
   // ALU functions
   typedef enum logic [2:0] {
      IPP_ALU_ADD, IPP_ALU_SUB, IPP_ALU_AND, IPP_ALU_OR,
      IPP_ALU_XOR, IPP_ALU_ROTL, IPP_ALU_INC, IPP_ALU_DEC
   } ipp_alu_t;
   // Decoded instruction word supplied by program memory
   typedef struct packed {
      ipp_op_t op;
      ipp_alu_t alu_fn;
      logic [7:0] operand;
      logic [13:0] target;
      logic skip_if_zero;
   } ipp_instr_t;
endpackage : ipp_pkg

// File: src/ipp_core.sv
// Instruction phase pipeline: four-phase timing, fetch/execute overlap, ALU
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// [RL1] Four non-overlapping phases in fixed order
// [RL2] First phase advances PC and starts fetch
// [RL3] Phases two to four decode and execute
// [RL4] Four clock periods make one instruction cycle
// [RL5] Fetch overlaps execute, one per cycle
// [RL6] PC-changing instructions take one extra cycle
// [RL7] Branch: get target, then transfer control
// [RL8] RC mode puts fetch phase on spare pin
// [RL9] Spare pin output quarter rate, 1:3 duty
// [RL10] Single 8-bit ALU does all operations
// [RL11] Data passes through accumulator and ALU
// [RL12] Taken skip discards fetched word, dummy cycle
// [RL13] Low byte write jumps in page, dummy
// [RL14] Reset restarts phases at the first phase
module ipp_core #(
   parameter int PC_WIDTH = ipp_pkg::IPP_PC_WIDTH
) (
   input wire logic clock_in,
   input wire logic reset_in,
   input wire logic rc_mode_in,
   input wire ipp_pkg::ipp_instr_t instr_in,
   output logic [3:0] instruction_phase_clocks_out,
   output logic [13:0] fetch_addr_out,
   output logic fetch_strobe_out,
   output logic [7:0] acc_out,
   output logic [7:0] pc_low_byte_out,
   output logic dummy_cycle_out,
   output logic rc_spare_oscillator_pin_out,
   output logic rc_spare_oscillator_pin_oe_n_out
);
   import ipp_pkg::*;

   // Width check: the pipeline is built for the documented counter width
   if (PC_WIDTH != IPP_PC_WIDTH) begin : g_bad_width
      $error("PC_WIDTH must equal the package counter width");
   end

   logic [3:0] phase_q;
   logic [13:0] pc_q;
   logic [13:0] fetch_addr_q;
   logic fetch_strobe_q;
   ipp_instr_t ir_q;
   logic ir_valid_q;
   logic [7:0] acc_q;
   logic [7:0] alu_result;
   logic dummy_q;
   logic pin_q;
   logic pin_oe_n_q;
   logic fetch_phase;
   logic exec_phase;
   logic primed_q;
   logic take_branch;
   logic take_pcl;
   logic take_skip;
   logic [13:0] redirect_addr;

   assign fetch_phase = phase_q[0];
   assign exec_phase = phase_q[3];

   // Decisions about the word now executing; they act only at the phase-four edge
   assign take_branch = ir_valid_q && ir_q.op == IPP_OP_BRANCH; // RL7
   assign take_pcl = ir_valid_q && ir_q.op == IPP_OP_PCL_WRITE; // RL13
   // A skip is taken when the zero test of the ALU result matches the request
   assign take_skip = ir_valid_q && ir_q.op == IPP_OP_SKIP
      && ((alu_result == 8'h00) == ir_q.skip_if_zero); // RL12
   // New fetch address: full branch target, or a jump kept inside the current page
   assign redirect_addr = take_branch ? ir_q.target : {pc_q[13:8], alu_result}; // RL7 RL13

   // Phase ring: one-hot rotation, restart at phase one on reset
   always_ff @(posedge clock_in) begin
      if (reset_in) begin
         phase_q <= IPP_PHASE_RESET; // RL14
      end else begin
         phase_q <= {phase_q[2:0], phase_q[3]}; // RL1 RL4
      end
   end

   // Armed by the first phase four after reset; until then no word has been fetched,
   // so the word sampled at the end of that first cycle must not execute
   always_ff @(posedge clock_in) begin
      if (reset_in) begin
         primed_q <= 1'b0;
      end else if (phase_q[3]) begin
         primed_q <= 1'b1; // RL14
      end
   end

   // Program counter and fetch: advance at the start of phase one
   always_ff @(posedge clock_in) begin
      if (reset_in) begin
         pc_q <= IPP_PC_RESET;
         fetch_addr_q <= IPP_PC_RESET;
         fetch_strobe_q <= 1'b0;
      end else begin
         fetch_strobe_q <= phase_q[3]; // RL2
         if (phase_q[3]) begin
            // A transfer fetches its target straight away in the dummy cycle, so the
            // counter must already point past it; otherwise the stale sequential
            // word would be fetched and then executed
            if (take_branch || take_pcl) begin
               fetch_addr_q <= redirect_addr; // RL7 RL13
               pc_q <= redirect_addr + 14'h0001; // RL6
            end else begin
               fetch_addr_q <= pc_q; // RL2
               pc_q <= pc_q + 14'h0001; // RL2 RL5
            end
         end
      end
   end

   // Instruction register: word fetched last cycle executes this cycle
   always_ff @(posedge clock_in) begin
      if (reset_in) begin
         ir_q <= '0;
         ir_valid_q <= 1'b0;
         dummy_q <= 1'b0;
      end else if (exec_phase) begin
         if (take_branch || take_pcl || take_skip) begin
            ir_valid_q <= 1'b0; // RL6 RL12
            dummy_q <= 1'b1;
         end else begin
            ir_q <= instr_in; // RL5
            ir_valid_q <= primed_q; // RL14
            dummy_q <= 1'b0;
         end
      end
   end

   // Single 8-bit ALU, operands flow from accumulator
   always_comb begin
      case (ir_q.alu_fn) // RL10 RL11
         IPP_ALU_ADD: alu_result = acc_q + ir_q.operand;
         IPP_ALU_SUB: alu_result = acc_q - ir_q.operand;
         IPP_ALU_AND: alu_result = acc_q & ir_q.operand;
         IPP_ALU_OR: alu_result = acc_q | ir_q.operand;
         IPP_ALU_XOR: alu_result = acc_q ^ ir_q.operand;
         IPP_ALU_ROTL: alu_result = {acc_q[6:0], acc_q[7]};
         IPP_ALU_INC: alu_result = acc_q + 8'h01;
         IPP_ALU_DEC: alu_result = acc_q - 8'h01;
         default: alu_result = acc_q;
      endcase
   end

   // Accumulator writeback at end of the execute phases
   always_ff @(posedge clock_in) begin
      if (reset_in) begin
         acc_q <= IPP_ACC_RESET;
      end else if (exec_phase && ir_valid_q && ir_q.op == IPP_OP_ALU) begin
         acc_q <= alu_result; // RL3 RL11
      end
   end

   // Spare pin: driven with the fetch phase only in RC mode
   always_ff @(posedge clock_in) begin
      if (reset_in) begin
         pin_q <= 1'b0;
         pin_oe_n_q <= 1'b1;
      end else begin
         pin_oe_n_q <= ~rc_mode_in; // RL8
         pin_q <= rc_mode_in & phase_q[3]; // RL9
      end
   end

   assign instruction_phase_clocks_out = phase_q;
   assign fetch_addr_out = fetch_addr_q;
   assign fetch_strobe_out = fetch_strobe_q;
   assign acc_out = acc_q;
   assign pc_low_byte_out = pc_q[7:0];
   assign dummy_cycle_out = dummy_q;
   assign rc_spare_oscillator_pin_out = pin_q;
   assign rc_spare_oscillator_pin_oe_n_out = pin_oe_n_q;

   // Checks: phase ring and reset
   a_phase_onehot: assert property (@(posedge clock_in) disable iff (reset_in) // RL1
      $onehot(phase_q)) else $error("phase not one-hot");
   a_phase_order: assert property (@(posedge clock_in) disable iff (reset_in) // RL4
      phase_q[0] |=> phase_q[1] ##1 phase_q[2] ##1 phase_q[3] ##1 phase_q[0])
      else $error("phase order wrong");
   a_reset_phase: assert property (@(posedge clock_in) // RL14
      reset_in |=> phase_q == IPP_PHASE_RESET) else $error("phase not restarted");
   // Checks: fetch and overlap; the first cycle after reset fetches nothing
   a_fetch_strobe_phase: assert property (@(posedge clock_in) disable iff (reset_in) // RL2
      fetch_strobe_q == (fetch_phase && primed_q)) else $error("fetch not in phase one");
   a_pc_advance: assert property (@(posedge clock_in) disable iff (reset_in) // RL5
      (exec_phase && !(take_branch || take_pcl)) |=> pc_q == $past(pc_q) + 14'h0001)
      else $error("pc not advanced");
   a_word_taken: assert property (@(posedge clock_in) disable iff (reset_in) // RL5
      (exec_phase && primed_q && !(take_branch || take_pcl || take_skip)) |=> ir_valid_q)
      else $error("fetched word not taken");
   // Checks: control transfers and dummy cycles
   a_branch_target: assert property (@(posedge clock_in) disable iff (reset_in) // RL7
      (exec_phase && take_branch) |=> fetch_addr_q == $past(ir_q.target)
      && pc_q == $past(ir_q.target) + 14'h0001 && !ir_valid_q && dummy_q)
      else $error("branch transfer wrong");
   a_dummy_cause: assert property (@(posedge clock_in) disable iff (reset_in) // RL6
      $rose(dummy_q) |-> $past(exec_phase && (take_branch || take_pcl || take_skip)))
      else $error("dummy cycle without transfer");
   a_dummy_recovers: assert property (@(posedge clock_in) disable iff (reset_in) // RL6
      (exec_phase && dummy_q) |=> ir_valid_q && !dummy_q)
      else $error("dummy lasted too long");
   a_skip_discard: assert property (@(posedge clock_in) disable iff (reset_in) // RL12
      (exec_phase && take_skip) |=> !ir_valid_q && dummy_q && fetch_addr_q == $past(pc_q))
      else $error("skip did not discard");
   a_pcl_page: assert property (@(posedge clock_in) disable iff (reset_in) // RL13
      (exec_phase && take_pcl) |=> dummy_q
      && fetch_addr_q == {$past(pc_q[13:8]), $past(alu_result)})
      else $error("page jump wrong");
   // Checks: datapath and spare pin
   a_acc_steady: assert property (@(posedge clock_in) disable iff (reset_in) // RL3
      !exec_phase |=> acc_q == $past(acc_q)) else $error("acc changed outside execute");
   a_pin_duty: assert property (@(posedge clock_in) disable iff (reset_in) // RL9
      ($rose(pin_q)) |=> !pin_q [*3] ##1 (pin_q || !rc_mode_in || $past(!rc_mode_in)))
      else $error("pin duty wrong");
   a_pin_enable: assert property (@(posedge clock_in) disable iff (reset_in) // RL8
      !rc_mode_in |=> pin_oe_n_q && !pin_q) else $error("pin driven outside RC mode");
   // Covers for the main scenarios
   c_branch: cover property (@(posedge clock_in) exec_phase && take_branch);
   c_skip: cover property (@(posedge clock_in) exec_phase && dummy_q && ir_q.op == IPP_OP_SKIP);
   c_pcl: cover property (@(posedge clock_in) exec_phase && take_pcl);
   c_pin: cover property (@(posedge clock_in) $rose(pin_q));
   c_dummy: cover property (@(posedge clock_in) $rose(dummy_q));
endmodule : ipp_core
`default_nettype wire

// File: tb/tb_top.sv
// Self-checking bench for the instruction phase pipeline
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   import ipp_pkg::*;
   logic clock_in = 1'b0;
   logic reset_in = 1'b1;
   logic rc_mode_in = 1'b0;
   ipp_instr_t instr_in = '0;
   logic [3:0] ph;
   logic [13:0] fa;
   logic [13:0] a;
   logic [13:0] exp_a;
   logic [7:0] acc;
   logic [7:0] plb;
   logic strobe, dummy, pin, pin_oe_n;
   int error_cnt = 0;
   int compares = 0;
   int highs;
   ipp_core i_dut (.clock_in(clock_in), .reset_in(reset_in), .rc_mode_in(rc_mode_in),
      .instr_in(instr_in), .instruction_phase_clocks_out(ph), .fetch_addr_out(fa),
      .fetch_strobe_out(strobe), .acc_out(acc), .pc_low_byte_out(plb), .dummy_cycle_out(dummy),
      .rc_spare_oscillator_pin_out(pin), .rc_spare_oscillator_pin_oe_n_out(pin_oe_n));
   // Free-running 5 ns clock
   initial begin
      forever #2.5 clock_in = ~clock_in;
   end
   // Compare one value and count it
   task automatic check(string name, logic [15:0] e, logic [15:0] g);
      compares++;
      if (g !== e) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", name, e, g);
      end
   endtask : check
   // Reference ALU
   function automatic logic [7:0] alu(ipp_alu_t f, logic [7:0] x, logic [7:0] y);
      case (f)
         IPP_ALU_ADD: return x + y;
         IPP_ALU_SUB: return x - y;
         IPP_ALU_AND: return x & y;
         IPP_ALU_OR: return x | y;
         IPP_ALU_XOR: return x ^ y;
         IPP_ALU_ROTL: return {x[6:0], x[7]};
         IPP_ALU_INC: return x + 8'h01;
         default: return x - 8'h01;
      endcase
   endfunction : alu
   // Settle in the next fetch phase
   task automatic wait_fetch();
      do begin
         @(posedge clock_in);
         #1;
      end while (ph !== 4'h1);
   endtask : wait_fetch
   // Present a word for the address being fetched, held through phase four
   task automatic run(ipp_instr_t i);
      wait_fetch();
      @(posedge clock_in);
      instr_in <= i;
      #1;
   endtask : run
   // Reset, then walk two instruction cycles of phases
   task automatic reset_phases();
      @(posedge clock_in);
      reset_in <= 1'b1;
      repeat (10) @(posedge clock_in);
      reset_in <= 1'b0;
      #1;
      check("acc", 16'h0000, acc);
      check("fetch_addr", 16'h0000, fa);
      for (int n = 0; n < 8; n++) begin
         check("phases", 16'h0001 << (n % 4), ph);
         check("strobe", {15'h0000, n == 4}, strobe);
         check("pc_low_byte", (n < 4) ? 16'h0000 : 16'h0001, plb);
         @(posedge clock_in);
         #1;
      end
   endtask : reset_phases
   // Every ALU function through the accumulator
   task automatic alu_ops();
      logic [7:0] e;
      for (int f = 0; f < 8; f++) begin
         run('{IPP_OP_ALU, ipp_alu_t'(f), 8'h35 + f[7:0], 14'h0000, 1'b0});
         e = alu(ipp_alu_t'(f), acc, 8'h35 + f[7:0]);
         run('0);
         wait_fetch();
         check("acc", {8'h00, e}, acc);
      end
   endtask : alu_ops
   // Control transfer: dummy cycle that fetches the new address, then its successor
   task automatic jump(ipp_op_t op, logic s);
      wait_fetch();
      a = fa;
      exp_a = (op == IPP_OP_BRANCH) ? 14'h02a5 : (op == IPP_OP_SKIP) ? a + 14'h0002 : {a[13:8], 8'h00};
      @(posedge clock_in);
      instr_in <= '{op, IPP_ALU_AND, 8'h00, 14'h02a5, s};
      run('0);
      check("sequential fetch", {2'b00, a + 14'h0001}, fa);
      wait_fetch();
      check("fetch_addr", {2'b00, exp_a}, fa);
      check("pc_low_byte", {8'h00, exp_a[7:0] + 8'h01}, plb);
      @(posedge clock_in);
      #1;
      check("dummy", 16'h0001, dummy);
      run('0);
      check("fetch_addr", {2'b00, exp_a + 14'h0001}, fa);
      check("dummy", 16'h0000, dummy);
   endtask : jump
   // Spare pin in and out of RC mode
   task automatic rc_pin();
      @(posedge clock_in);
      rc_mode_in <= 1'b1;
      repeat (3) @(posedge clock_in);
      highs = 0;
      for (int n = 0; n < 8; n++) begin
         @(posedge clock_in);
         #1;
         highs += pin;
         check("pin", {15'h0000, ph[0]}, pin);
         check("pin_oe_n", 16'h0000, pin_oe_n);
      end
      check("pin highs", 16'h0002, highs);
      @(posedge clock_in);
      rc_mode_in <= 1'b0;
      repeat (3) @(posedge clock_in);
      #1;
      check("pin_oe_n", 16'h0001, pin_oe_n);
      check("pin", 16'h0000, pin);
   endtask : rc_pin
   // Verdict and end of run
   task automatic finish_test();
      $display("compares %0d error_cnt %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : finish_test
   // Main sequence
   initial begin
      reset_phases();
      alu_ops();
      jump(IPP_OP_BRANCH, 1'b0);
      jump(IPP_OP_SKIP, 1'b1);
      jump(IPP_OP_PCL_WRITE, 1'b0);
      rc_pin();
      reset_phases();
      finish_test();
   end
   // Watchdog
   initial begin
      #20000;
      error_cnt++;
      finish_test();
   end
endmodule : tb_top
`default_nettype wire
